// ==== design/ssp_player.sv ====
/*
 Serial solenoid command player: UART receiver, two-byte command parser,
 play tick and six attack/hold channel sequencers driving twelve outputs.
 Assumes RXD and BOARD_ADDR come from pins and are asynchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module ssp_player
	import ssp_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic RXD,
	input wire logic [2:0] BOARD_ADDR,
	output logic [NOUT-1:0] OUT,
	output logic DEFERRED,
	output logic [NCH-1:0] PENDING
);

	ssp_state_s s;
	ssp_state_s n;
	logic cmd_go;
	logic [2:0] cmd_ch;
	logic [6:0] cmd_val;
	logic cmd_play;

	// Command decode of the registered byte
	always_comb begin
		cmd_val = s.byte_val[VAL_MSB:0];
		cmd_go = s.byte_vld && !s.byte_val[STAT_BIT] && s.have_stat && s.stat_match;
		cmd_ch = 3'(s.stat_op >> 1);
		cmd_play = (s.stat_op <= OP_LAST_PLAY);
	end

	// Next state
	always_comb begin
		logic [NCH-1:0] start_v;
		logic [NCH-1:0] stop_v;
		logic [NCH-1:0][6:0] start_velo;
		logic [CNT_W-1:0] len;
		start_v = '0;
		stop_v = '0;
		start_velo = '0;
		len = '0;
		n = s;
		// Two-stage synchronisers on pins
		n.rx_s1 = RXD;
		n.rx_s2 = s.rx_s1;
		n.adr_s1 = BOARD_ADDR;
		n.adr_s2 = s.adr_s1;
		n.byte_vld = 1'b0;

		// 8N1 receiver, mid-bit sampling
		case (s.rx_state)
			RX_IDLE: begin
				if (!s.rx_s2) begin
					n.rx_state = RX_START;
					n.rx_cnt = RXC_W'(HALF_CYC - 1);
				end
			end
			RX_START: begin
				if (s.rx_cnt == '0) begin
					if (!s.rx_s2) begin
						n.rx_state = RX_DATA;
						n.rx_cnt = RXC_W'(BIT_CYC - 1);
						n.rx_bit = '0;
					end else begin
						n.rx_state = RX_IDLE;
					end
				end else begin
					n.rx_cnt = s.rx_cnt - 1'b1;
				end
			end
			RX_DATA: begin
				if (s.rx_cnt == '0) begin
					n.rx_shift = {s.rx_s2, s.rx_shift[LAST_BIT:1]};
					n.rx_cnt = RXC_W'(BIT_CYC - 1);
					n.rx_bit = s.rx_bit + 1'b1;
					if (s.rx_bit == 3'(LAST_BIT)) begin
						n.rx_state = RX_STOP;
					end
				end else begin
					n.rx_cnt = s.rx_cnt - 1'b1;
				end
			end
			RX_STOP: begin
				if (s.rx_cnt == '0) begin
					// Framing error drops the byte
					n.byte_vld = s.rx_s2;
					n.byte_val = s.rx_shift;
					n.rx_state = RX_IDLE;
				end else begin
					n.rx_cnt = s.rx_cnt - 1'b1;
				end
			end
			default: begin
				n.rx_state = RX_IDLE;
			end
		endcase

		// Play tick divider
		if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			n.tick_cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = s.tick_cnt + 1'b1;
			n.tick = 1'b0;
		end

		// Command parser
		if (s.byte_vld) begin
			if (s.byte_val[STAT_BIT]) begin
				n.have_stat = 1'b1;
				n.stat_op = s.byte_val[OP_MSB:0];
				n.stat_match = (s.byte_val[ADR_MSB:ADR_LSB] == s.adr_s2);
			end else begin
				// Orphan data bytes fall through unused
				n.have_stat = 1'b0;
			end
		end
		if (cmd_go) begin
			if (cmd_play) begin
				if (cmd_val == '0) begin
					stop_v[cmd_ch] = 1'b1;
				end else if (s.deferred) begin
					n.pend[cmd_ch] = 1'b1;
					n.pend_velo[cmd_ch] = cmd_val;
				end else begin
					start_v[cmd_ch] = 1'b1;
					start_velo[cmd_ch] = cmd_val;
				end
			end else if (s.stat_op == OP_SCALE) begin
				n.scale = cmd_val;
			end else if (s.stat_op == OP_MODE) begin
				n.deferred = cmd_val[MODE_BIT];
			end else if (s.stat_op == OP_SYNC) begin
				start_v = s.pend;
				start_velo = s.pend_velo;
				n.pend = '0;
			end
			// Opcode 14 has no effect
		end

		// Channel sequencers
		for (int c = 0; c < NCH; c++) begin
			len = CNT_W'(s.scale) * CNT_W'(start_velo[c]);
			if (stop_v[c]) begin
				n.att[c] = 1'b0;
				n.hold[c] = 1'b0;
				n.pend[c] = 1'b0;
				n.remain[c] = '0;
			end else if (start_v[c]) begin
				// Restart drops any running phase
				n.att[c] = (len != '0);
				n.hold[c] = (len == '0);
				n.remain[c] = len;
			end else if (s.att[c] && s.tick) begin
				if (s.remain[c] <= CNT_W'(1)) begin
					n.att[c] = 1'b0;
					n.hold[c] = 1'b1;
					n.remain[c] = '0;
				end else begin
					n.remain[c] = s.remain[c] - 1'b1;
				end
			end
			n.outp[2*c] = n.att[c];
			n.outp[2*c+1] = n.hold[c];
		end
	end

	// State register with synchronous reset
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			s <= '0;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
			s.rx_state <= RX_IDLE;
			s.scale <= SCALE_RST;
			s.deferred <= 1'b0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from state flops
	assign OUT = s.outp;
	assign DEFERRED = s.deferred;
	assign PENDING = s.pend;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	a_reset_values: assert property ($past(!RESET_N) |->
		s.outp == '0 && s.pend == '0 && s.scale == SCALE_RST && !s.deferred)
		else $error("bad state after reset");

	a_tick_period: assert property (s.tick |->
		$past(s.tick_cnt) == TICK_W'(TICK_CYCLES - 1) && s.tick_cnt == '0)
		else $error("tick out of period");

	a_status_capture: assert property (s.byte_vld && s.byte_val[STAT_BIT] |=>
		s.have_stat && s.stat_op == $past(s.byte_val[OP_MSB:0])
		&& s.stat_match == ($past(s.byte_val[ADR_MSB:ADR_LSB]) == $past(s.adr_s2)))
		else $error("status byte not captured");

	a_orphan_data: assert property (s.byte_vld && !s.byte_val[STAT_BIT] && !s.have_stat |=>
		$stable(s.scale) && $stable(s.deferred) && $stable(s.pend) && !s.have_stat)
		else $error("orphan data changed state");

	a_scale_load: assert property (cmd_go && s.stat_op == OP_SCALE |=>
		s.scale == $past(cmd_val))
		else $error("scale not loaded");

	a_mode_select: assert property (cmd_go && s.stat_op == OP_MODE |=>
		s.deferred == $past(cmd_val[MODE_BIT]))
		else $error("mode not set");

	a_immediate_play: assert property (cmd_go && cmd_play && cmd_val != '0
		&& !s.deferred && s.scale != '0 |=>
		s.outp[2*$past(cmd_ch)] && !s.outp[2*$past(cmd_ch)+1]
		&& s.remain[$past(cmd_ch)] == CNT_W'($past(s.scale)) * CNT_W'($past(cmd_val)))
		else $error("immediate play did not start attack");

	a_deferred_wait: assert property (cmd_go && cmd_play && cmd_val != '0 && s.deferred |=>
		s.pend[$past(cmd_ch)] && s.pend_velo[$past(cmd_ch)] == $past(cmd_val))
		else $error("deferred play not held");

	a_sync_start: assert property (cmd_go && s.stat_op == OP_SYNC && s.pend[0] && s.scale != '0 |=>
		s.pend == '0 && s.att[0])
		else $error("sync did not start pending");

	a_stop_output: assert property (cmd_go && cmd_play && cmd_val == '0 |=>
		!s.outp[2*$past(cmd_ch)] && !s.outp[2*$past(cmd_ch)+1])
		else $error("stop left output driven");

	a_attack_hold: assert property (s.att[0] && s.tick && s.remain[0] == CNT_W'(1)
		&& !cmd_go |=> !s.att[0] && s.hold[0] ##1 s.outp[1] || !s.outp[0])
		else $error("attack did not hand over to hold");

endmodule // ssp_player

`default_nettype wire

// ==== design/ssp_pkg.sv ====
/*
 Shared constants and types for the serial solenoid command player.
 Assumes a 25 MHz system clock and a host sending 8N1 frames at 115200 baud.
*/
package ssp_pkg;

	// Clock and serial timing
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int BAUD = 115200;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int RXC_W = 8;

	// Play tick, 0.4 ms
	localparam int TICK_NS = 400_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int TICK_W = 16;

	// Byte layout
	localparam int STAT_BIT = 7;
	localparam int ADR_MSB = 6;
	localparam int ADR_LSB = 4;
	localparam int OP_MSB = 3;
	localparam int VAL_MSB = 6;
	localparam int MODE_BIT = 0;
	localparam int LAST_BIT = 7;

	// Opcodes
	localparam logic [3:0] OP_LAST_PLAY = 4'hB;
	localparam logic [3:0] OP_SCALE = 4'hC;
	localparam logic [3:0] OP_MODE = 4'hD;
	localparam logic [3:0] OP_SYNC = 4'hF;

	// Channels and reset values
	localparam int NCH = 6;
	localparam int NOUT = 12;
	localparam int CNT_W = 14;
	localparam logic [6:0] SCALE_RST = 7'h01;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} ssp_rx_e;

	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic [2:0] adr_s1;
		logic [2:0] adr_s2;
		ssp_rx_e rx_state;
		logic [RXC_W-1:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic byte_vld;
		logic [7:0] byte_val;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic have_stat;
		logic stat_match;
		logic [3:0] stat_op;
		logic [6:0] scale;
		logic deferred;
		logic [NCH-1:0] pend;
		logic [NCH-1:0][6:0] pend_velo;
		logic [NCH-1:0] att;
		logic [NCH-1:0] hold;
		logic [NCH-1:0][CNT_W-1:0] remain;
		logic [NOUT-1:0] outp;
	} ssp_state_s;

endpackage

// ==== test/ssp_host.sv ====
/*
 Host model: sends 8N1 frames at 115200 baud and two-byte commands on RXD.
 Assumes the clock it is given is the player's 25 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ssp_host
	import ssp_pkg::*;
(
	input wire logic sys_clk,
	output var logic rxd
);
	// Line idles high between frames
	initial rxd = 1'b1;

	// One frame, start bit then LSB first, full stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge sys_clk);
			rxd = frame[i];
			repeat (BIT_CYC - 1) @(negedge sys_clk);
		end
	endtask

	// Status byte then data byte
	task automatic send_cmd(input logic [2:0] adr, input logic [3:0] op, input logic [6:0] val);
		send_byte({1'b1, adr, op});
		send_byte({1'b0, val});
	endtask
endmodule // ssp_host

`default_nettype wire

// ==== test/tb_ssp_player.sv ====
/*
 Testbench for the solenoid command player: sends commands through the host
 model and checks outputs. Assumes a short play tick of 20 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ssp_player
	import ssp_pkg::*;
;
	localparam int TK = 20;
	logic SYS_CLK;
	logic RESET_N;
	logic [2:0] BOARD_ADDR;
	logic RXD;
	logic [NOUT-1:0] OUT;
	logic DEFERRED;
	logic [NCH-1:0] PENDING;
	int fails = 0;
	int total_checks = 0;

	ssp_host u_host (.sys_clk(SYS_CLK), .rxd(RXD));

	ssp_player #(.TICK_CYCLES(TK)) u_dut (
		.SYS_CLK(SYS_CLK),
		.RESET_N(RESET_N),
		.RXD(RXD),
		.BOARD_ADDR(BOARD_ADDR),
		.OUT(OUT),
		.DEFERRED(DEFERRED),
		.PENDING(PENDING)
	);

	// Clock, 40 ns period
	initial begin
		SYS_CLK = 1'b0;
		forever #(CLK_NS / 2) SYS_CLK = ~SYS_CLK;
	end

	task automatic cmp_out(input logic [NOUT-1:0] exp);
		total_checks++;
		if (OUT !== exp) begin
			fails++;
			$display("[ERR] OUT exp %h got %h", exp, OUT);
		end
	endtask

	task automatic cmp_mode(input logic [NCH:0] exp);
		total_checks++;
		if ({DEFERRED, PENDING} !== exp) begin
			fails++;
			$display("[ERR] DEFERRED_PENDING exp %h got %h", exp, {DEFERRED, PENDING});
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask

	// Command to this board
	task automatic cmd(input logic [3:0] op, input logic [6:0] val);
		u_host.send_cmd(BOARD_ADDR, op, val);
	endtask

	// Attack of 20 ticks began about 104 clocks before the command returned
	task automatic check_attack(input logic [NOUT-1:0] att, input logic [NOUT-1:0] hld);
		wait_clk(250);
		cmp_out(att);
		wait_clk(70);
		cmp_out(hld);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		// About 11 commands of roughly 4400 clocks each, one lone data byte, plus the attack waits
		repeat (90000) @(posedge SYS_CLK);
		fails++;
		$display("[ERR] watchdog exp done got hang");
		end_sim();
	end

	// Main sequence
	initial begin
		BOARD_ADDR = 3'h5;
		RESET_N = 1'b0;
		wait_clk(2);
		RESET_N = 1'b1;
		wait_clk(3);
		cmp_out(12'h000);
		cmp_mode(7'h00);
		// Host keeps every attack well under a quarter of the channel's on-time
		cmd(4'h0, 7'h14);
		check_attack(12'h001, 12'h002);
		cmd(4'h1, 7'h00);
		cmp_out(12'h000);
		cmd(4'hC, 7'h02);
		cmd(4'hA, 7'h0A);
		check_attack(12'h400, 12'h800);
		cmd(4'hB, 7'h0A);
		check_attack(12'h400, 12'h800);
		u_host.send_cmd(3'h2, 4'h2, 7'h14);
		cmp_out(12'h800);
		cmd(4'hE, 7'h7F);
		u_host.send_byte(8'h06);
		cmp_out(12'h800);
		cmp_mode(7'h00);
		cmd(4'hD, 7'h7F);
		cmp_mode(7'h40);
		cmd(4'h4, 7'h14);
		cmp_mode(7'h44);
		cmp_out(12'h800);
		cmd(4'hF, 7'h00);
		cmp_mode(7'h40);
		cmp_out(12'h810);
		cmd(4'hD, 7'h7E);
		cmp_mode(7'h00);
		end_sim();
	end
endmodule // tb_ssp_player

`default_nettype wire
